// File: core/rsso_cfg.svh
// Constants for the resonant soft-start and on-time block
`ifndef RSSO_CFG_SVH
`define RSSO_CFG_SVH
`define RSSO_CNT_W        12
`define RSSO_MAX_ON       12'hfff
`define RSSO_SS_STEP      12'h004
`define RSSO_SS_DIV       4'h1
`define RSSO_FAULT_N      4'h4
`define RSSO_DEAD_NS      100
`define RSSO_CLK_NS       8
`define RSSO_DEAD_CYC     ((`RSSO_DEAD_NS + `RSSO_CLK_NS - 1) / `RSSO_CLK_NS)
`define RSSO_SKIP_OFF_CYC 16'h0400
`define RSSO_QS_FRAME     16'h4000
`define RSSO_QS_STEP      16'h0010
`endif

// File: core/rsso_pkg.sv
// Types for the resonant soft-start and on-time block
package rsso_pkg;
   typedef enum logic [2:0] {
      RSSO_IDLE, RSSO_HIGH, RSSO_DEAD_HL, RSSO_LOW, RSSO_DEAD_LH, RSSO_SKIP_OFF, RSSO_FAULT
   } rsso_phase_e;
   typedef logic [11:0] rsso_count_t;
endpackage

// File: core/rsso_sync.sv
// Three-stage input synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module rsso_sync (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic din,
   output logic      dout
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clock) begin
      if (srst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         dout <= 1'b0;
      end else if (s2 == s3) begin
         dout <= s3;
      end
   end
endmodule

// File: core/rsso_softstart.sv
// Saturating soft-start counter clocked by low-side pulses
`timescale 1ns/1ps
`include "rsso_cfg.svh"
module rsso_softstart #(
   parameter int          W     = `RSSO_CNT_W,
   parameter logic [11:0] STEP  = `RSSO_SS_STEP,
   parameter logic [3:0]  DIV   = `RSSO_SS_DIV,
   parameter logic [11:0] MAXV  = `RSSO_MAX_ON
) (
   input  wire logic         clock,
   input  wire logic         srst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   input  wire logic         low_pulse_start,
   input  wire logic         force_max,
   output logic [W-1:0]      count,
   output logic              at_max
);
   logic [3:0] div_cnt;
   logic [W:0] sum;

   assign sum    = {1'b0, count} + {1'b0, STEP};
   assign at_max = (count == MAXV);

   always_ff @(posedge clock) begin
      if (srst || load) begin
         div_cnt <= 4'h0;
      end else if (low_pulse_start) begin
         div_cnt <= (div_cnt + 4'h1 >= DIV) ? 4'h0 : div_cnt + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         count <= '0;
      end else if (force_max) begin
         count <= MAXV;
      end else if (load) begin
         count <= load_value;
      end else if (low_pulse_start && (div_cnt + 4'h1 >= DIV)) begin
         // Up only, saturates at the longest on-time
         count <= (sum > {1'b0, MAXV}) ? MAXV : sum[W-1:0];
      end
   end

   chk_ss_monotonic: assert property (@(posedge clock) disable iff (srst)
      !$past(load) && !$past(srst) && !load |-> count >= $past(count))
      else $error("soft-start counter went down");
   chk_ss_ceiling: assert property (@(posedge clock) disable iff (srst)
      count <= MAXV) else $error("soft-start counter above maximum");
   chk_ss_force: assert property (@(posedge clock) disable iff (srst)
      force_max |=> at_max) else $error("skip entry did not end soft-start");
endmodule

// File: core/rsso_core.sv
// Soft-start and on-time generation for a half-bridge resonant controller
//
// What this block does
// - Load soft-start counter at startup end
// - Soft-start counts up, saturates at maximum
// - Add step each low-side on-time
// - Optionally divide low-side pulse clock
// - Skip-entry feedback forces counter to maximum
// - On-time counts up high, down low
// - Reverse at maximum or current-sense end
// - Repeated maximum hits enter protection
// - Limit reference reloads from soft-start
// - Maximum fault ignored until soft-start done
// - Ramp output follows soft-start counter
// - First high-side counts from zero
// - Dead time then low until zero
// - Comparator lows only feed repetition enable, never end high-side
// - Repetition disabled when soft-start begins
// - Repetition re-enabled on periodic comparator lows
// - Light load adds off-time after each cycle
// - Quiet skip regulates burst frequency
// - Startup done when ZVS time short
`timescale 1ns/1ps
`include "rsso_cfg.svh"
module rsso_core
   import rsso_pkg::*;
#(
   parameter int          W        = `RSSO_CNT_W,
   parameter logic [11:0] SS_STEP  = `RSSO_SS_STEP,
   parameter logic [3:0]  SS_DIV   = `RSSO_SS_DIV,
   parameter logic [3:0]  FAULT_N  = `RSSO_FAULT_N,
   parameter bit          LATCHED  = 1'b1,
   parameter int          DEAD_CYC = `RSSO_DEAD_CYC
) (
   input  wire logic            clock,
   input  wire logic            srst,
   input  wire logic            startup_done,
   input  wire rsso_pkg::rsso_count_t startup_on_time,
   input  wire logic            zvs_time_short,
   input  wire logic            cs_terminate,
   input  wire logic            on_time_cmp,
   input  wire logic            fb_below_skip_entry,
   input  wire logic            fb_below_light_load,
   input  wire logic            fb_below_quiet_skip,
   input  wire logic            fault_clear,
   output logic                 gate_driver_output_high,
   output logic                 gate_driver_output_low,
   output rsso_pkg::rsso_count_t ss_dac_code,
   output logic                 soft_start_active,
   output logic                 repeat_enable,
   output logic                 protection_active,
   output logic                 quiet_skip_active
);
   import rsso_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers for comparator pins
   // ----------------------------------------------------------------
   logic cs_s;
   logic otc_s;
   logic skip_s;
   logic light_s;
   logic quiet_s;

   rsso_sync u_sync_cs    (.clock(clock), .srst(srst), .din(cs_terminate),        .dout(cs_s));
   rsso_sync u_sync_otc   (.clock(clock), .srst(srst), .din(on_time_cmp),         .dout(otc_s));
   rsso_sync u_sync_skip  (.clock(clock), .srst(srst), .din(fb_below_skip_entry), .dout(skip_s));
   rsso_sync u_sync_light (.clock(clock), .srst(srst), .din(fb_below_light_load), .dout(light_s));
   rsso_sync u_sync_quiet (.clock(clock), .srst(srst), .din(fb_below_quiet_skip), .dout(quiet_s));

   // ----------------------------------------------------------------
   // State and counters
   // ----------------------------------------------------------------
   rsso_phase_e  phase;
   logic [W-1:0] on_cnt;
   logic [W-1:0] max_ref;
   logic [W-1:0] ss_count;
   logic         ss_at_max;
   logic         ss_load;
   logic [7:0]   dead_cnt;
   logic [3:0]   fault_cnt;
   logic [15:0]  off_cnt;
   logic [15:0]  skip_off_len;
   logic [15:0]  frame_cnt;
   logic [3:0]   burst_cnt;
   logic         low_pulse_start;
   logic         reverse;
   logic         hit_max;
   logic         otc_low_seen;
   logic [1:0]   otc_low_cycles;

   // switching starts only when startup_done and zvs_time_short are both high while idle
   assign ss_load = startup_done && zvs_time_short && (phase == RSSO_IDLE);

   rsso_softstart #(
      .W(W), .STEP(SS_STEP), .DIV(SS_DIV), .MAXV(`RSSO_MAX_ON)
   ) u_ss (
      .clock           (clock),
      .srst            (srst),
      .load            (ss_load),
      .load_value      (startup_on_time),
      .low_pulse_start (low_pulse_start),
      .force_max       (skip_s && soft_start_active),
      .count           (ss_count),
      .at_max          (ss_at_max)
   );

   // Limit sits at soft-start value while ramping, full limit after
   assign hit_max = (on_cnt + 12'h001 >= max_ref);
   // Current-sense end or the limit, whichever comes first, reverses the count
   assign reverse = cs_s || hit_max;
   assign low_pulse_start = (phase == RSSO_DEAD_HL) && (dead_cnt == 8'h00);

   // ----------------------------------------------------------------
   // Phase sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         phase <= RSSO_IDLE;
      end else begin
         case (phase)
            RSSO_IDLE:     if (ss_load) begin
                              phase <= RSSO_HIGH;
                           end
            RSSO_HIGH:     if (reverse) begin
                              phase <= RSSO_DEAD_HL;
                           end
            RSSO_DEAD_HL:  if (dead_cnt == 8'h00) begin
                              phase <= RSSO_LOW;
                           end
            RSSO_LOW:      if (on_cnt <= 12'h001) begin
                              phase <= RSSO_DEAD_LH;
                           end
            RSSO_DEAD_LH:  if (dead_cnt == 8'h00) begin
                              if (protection_active) begin
                                 phase <= RSSO_FAULT;
                              end else if (!soft_start_active && (light_s || quiet_s)) begin
                                 phase <= RSSO_SKIP_OFF;
                              end else begin
                                 phase <= RSSO_HIGH;
                              end
                           end
            RSSO_SKIP_OFF: if (protection_active) begin
                              phase <= RSSO_FAULT;
                           end else if (off_cnt == 16'h0000) begin
                              phase <= RSSO_HIGH;
                           end
            RSSO_FAULT:    if (!LATCHED && fault_clear) begin
                              phase <= RSSO_IDLE;
                           end
            default:       phase <= RSSO_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Bidirectional on-time counter
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         on_cnt <= '0;
      end else if (phase == RSSO_IDLE || phase == RSSO_SKIP_OFF) begin
         on_cnt <= '0;
      end else if (phase == RSSO_HIGH && !reverse) begin
         on_cnt <= on_cnt + 12'h001;
      end else if (phase == RSSO_HIGH) begin
         on_cnt <= on_cnt + 12'h001;
      end else if (phase == RSSO_LOW && on_cnt != '0) begin
         on_cnt <= on_cnt - 12'h001;
      end
   end

   // Dead time between the two drivers
   always_ff @(posedge clock) begin
      if (srst) begin
         dead_cnt <= 8'h00;
      end else if (phase == RSSO_HIGH || phase == RSSO_LOW) begin
         dead_cnt <= 8'(DEAD_CYC - 1);
      end else if (dead_cnt != 8'h00) begin
         dead_cnt <= dead_cnt - 8'h01;
      end
   end

   // Limit reference reloaded at each cycle start during soft-start
   always_ff @(posedge clock) begin
      if (srst) begin
         max_ref <= '0;
      end else if (phase == RSSO_DEAD_LH && dead_cnt == 8'h00) begin
         max_ref <= soft_start_active ? ss_count : `RSSO_MAX_ON;
      end else if (phase == RSSO_IDLE) begin
         // First soft-start pulse runs to the loaded startup on-time
         max_ref <= startup_on_time;
      end
   end

   // ----------------------------------------------------------------
   // Soft-start window and maximum on-time fault
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         soft_start_active <= 1'b0;
      end else if (ss_load) begin
         soft_start_active <= 1'b1;
      end else if (ss_at_max && phase != RSSO_IDLE) begin
         soft_start_active <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || phase == RSSO_IDLE) begin
         fault_cnt <= 4'h0;
      end else if (phase == RSSO_HIGH && hit_max && !cs_s && !soft_start_active) begin
         fault_cnt <= (fault_cnt == 4'hf) ? fault_cnt : fault_cnt + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         protection_active <= 1'b0;
      end else if (fault_cnt >= FAULT_N) begin
         protection_active <= 1'b1;
      end else if (!LATCHED && fault_clear && phase == RSSO_FAULT) begin
         protection_active <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Previous on-time repetition enable
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst || ss_load) begin
         otc_low_seen <= 1'b0;
      end else if (phase == RSSO_HIGH && !otc_s) begin
         otc_low_seen <= 1'b1;
      end else if (phase == RSSO_LOW) begin
         otc_low_seen <= 1'b0;
      end
   end

   // Two cycles in a row with a low comparator count as periodic
   always_ff @(posedge clock) begin
      if (srst || ss_load) begin
         otc_low_cycles <= 2'h0;
      end else if (phase == RSSO_DEAD_HL && dead_cnt == 8'h00) begin
         otc_low_cycles <= otc_low_seen ? ((otc_low_cycles == 2'h2) ? 2'h2 : otc_low_cycles + 2'h1)
                                        : 2'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || ss_load) begin
         repeat_enable <= 1'b0;
      end else if (otc_low_cycles == 2'h2) begin
         repeat_enable <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Light-load off-time and quiet skip burst regulation
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         off_cnt <= 16'h0000;
      end else if (phase == RSSO_DEAD_LH) begin
         off_cnt <= skip_off_len;
      end else if (off_cnt != 16'h0000) begin
         off_cnt <= off_cnt - 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         frame_cnt <= 16'h0000;
      end else begin
         frame_cnt <= (frame_cnt == `RSSO_QS_FRAME) ? 16'h0000 : frame_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || frame_cnt == `RSSO_QS_FRAME) begin
         burst_cnt <= 4'h0;
      end else if (phase == RSSO_SKIP_OFF && off_cnt == 16'h0000 && burst_cnt != 4'hf) begin
         burst_cnt <= burst_cnt + 4'h1;
      end
   end

   // Longer off-time when bursts come too often, shorter when too few
   always_ff @(posedge clock) begin
      if (srst) begin
         skip_off_len <= `RSSO_SKIP_OFF_CYC;
      end else if (!quiet_s) begin
         skip_off_len <= `RSSO_SKIP_OFF_CYC;
      end else if (frame_cnt == `RSSO_QS_FRAME) begin
         if (burst_cnt > 4'h1 && skip_off_len < 16'hffef) begin
            skip_off_len <= skip_off_len + `RSSO_QS_STEP;
         end else if (burst_cnt < 4'h1 && skip_off_len > `RSSO_SKIP_OFF_CYC) begin
            skip_off_len <= skip_off_len - `RSSO_QS_STEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         gate_driver_output_high <= 1'b0;
         gate_driver_output_low  <= 1'b0;
         ss_dac_code             <= '0;
         quiet_skip_active       <= 1'b0;
      end else begin
         gate_driver_output_high <= (phase == RSSO_HIGH) && !reverse;
         gate_driver_output_low  <= (phase == RSSO_LOW) && (on_cnt > 12'h001);
         // Ramp held at zero while idle, then starts from the loaded startup on-time
         ss_dac_code             <= (phase == RSSO_IDLE) ? '0 : ss_count;
         quiet_skip_active       <= quiet_s && !soft_start_active;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_no_overlap: assert property (@(posedge clock) disable iff (srst)
      !(gate_driver_output_high && gate_driver_output_low))
      else $error("both drivers on");
   chk_reverse_phase: assert property (@(posedge clock) disable iff (srst)
      phase == RSSO_HIGH && reverse |=> phase == RSSO_DEAD_HL)
      else $error("on-time did not reverse");
   chk_limit_ss: assert property (@(posedge clock) disable iff (srst)
      phase == RSSO_DEAD_LH && dead_cnt == 8'h00 && soft_start_active |=> max_ref == $past(ss_count))
      else $error("limit not reloaded from soft-start");
   chk_fault_mask: assert property (@(posedge clock) disable iff (srst)
      soft_start_active && !$past(soft_start_active) |=> fault_cnt == 4'h0)
      else $error("fault counted during soft-start");
   chk_protect_ent: assert property (@(posedge clock) disable iff (srst)
      fault_cnt >= FAULT_N |=> protection_active)
      else $error("protection not entered");
   chk_start_zero: assert property (@(posedge clock) disable iff (srst)
      ss_load |=> phase == RSSO_HIGH && on_cnt == '0)
      else $error("on-time did not start at zero");
   chk_repeat_off: assert property (@(posedge clock) disable iff (srst)
      ss_load |=> !repeat_enable) else $error("repetition still on at soft-start");
   chk_dac_follow: assert property (@(posedge clock) disable iff (srst)
      phase != RSSO_IDLE |=> ss_dac_code == $past(ss_count))
      else $error("ramp not following counter");
   chk_low_after: assert property (@(posedge clock) disable iff (srst)
      phase == RSSO_DEAD_HL ##1 phase == RSSO_LOW |-> ##[0:2] gate_driver_output_low || on_cnt <= 1)
      else $error("low side not driven after dead time");
   cov_ss_done:   cover property (@(posedge clock) soft_start_active ##1 !soft_start_active);
   cov_cs_end:    cover property (@(posedge clock) phase == RSSO_HIGH && cs_s);
   cov_protect:   cover property (@(posedge clock) $rose(protection_active));
   cov_skip:      cover property (@(posedge clock) phase == RSSO_SKIP_OFF);
endmodule

// File: verif/rsso_halfbridge_model.sv
// Behavioural half-bridge, current-sense and comparator model for the on-time block
`timescale 1ns/1ps
module rsso_halfbridge_model (
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       gate_high,
   input  wire logic       gate_low,
   input  wire logic       cs_en,
   input  wire logic       cmp_en,
   input  wire logic [7:0] cs_delay,
   output logic            cs_terminate,
   output logic            on_time_cmp
);
   // ------------------------------------------------
   // Primary current ramp seen during high-side drive
   // ------------------------------------------------
   logic [11:0] ramp;

   // Current only builds while the high side conducts; low side keeps it clear
   always_ff @(posedge clock) begin
      if (srst || !gate_high || gate_low) begin
         ramp         <= 12'h000;
         cs_terminate <= 1'b0;
         on_time_cmp  <= 1'b1;
      end else begin
         ramp         <= ramp + 12'h001;
         cs_terminate <= cs_en && (ramp >= {4'h0, cs_delay});
         // Comparator drops half way to the current limit once regulation acts
         on_time_cmp  <= !(cmp_en && (ramp >= {5'h00, cs_delay[7:1]}));
      end
   end
endmodule

// File: verif/tb_resonant_soft_start_ontime.sv
// Self-checking bench for the soft-start and on-time block
`timescale 1ns/1ps
`include "rsso_cfg.svh"
module tb_resonant_soft_start_ontime;
   import rsso_pkg::*;
   typedef struct packed {
      logic [11:0] dh;
      logic [11:0] dac;
   } rsso_note_s;

   logic        clock;
   logic        srst;
   logic        startup_done;
   rsso_count_t startup_on_time;
   logic        zvs_time_short;
   logic        cs_terminate;
   logic        on_time_cmp;
   logic        fb_below_skip_entry;
   logic        fb_below_light_load;
   logic        fb_below_quiet_skip;
   logic        qsa;
   logic        gh;
   logic        gl;
   rsso_count_t dac;
   logic        ss_act;
   logic        rep_en;
   logic        prot;
   logic        cs_en;
   logic        cmp_en;
   int          err_count;
   int          num_checks;
   int          cycles;
   int          hc;
   int          lc;
   int          dc;
   int          h;
   int          h0;
   int          done_cyc;
   int          i;
   int          off;
   logic        pgh;
   logic        pgl;
   logic [11:0] n0;
   rsso_note_s  notes[$];
   rsso_note_s  nt;

   rsso_core dut_u (
      .clock(clock), .srst(srst), .startup_done(startup_done),
      .startup_on_time(startup_on_time), .zvs_time_short(zvs_time_short),
      .cs_terminate(cs_terminate), .on_time_cmp(on_time_cmp),
      .fb_below_skip_entry(fb_below_skip_entry), .fb_below_light_load(fb_below_light_load),
      .fb_below_quiet_skip(fb_below_quiet_skip), .fault_clear(1'b0),
      .gate_driver_output_high(gh), .gate_driver_output_low(gl), .ss_dac_code(dac),
      .soft_start_active(ss_act), .repeat_enable(rep_en), .protection_active(prot),
      .quiet_skip_active(qsa)
   );

   rsso_halfbridge_model hb_u (
      .clock(clock), .srst(srst), .gate_high(gh), .gate_low(gl), .cs_en(cs_en),
      .cmp_en(cmp_en), .cs_delay(8'h14), .cs_terminate(cs_terminate),
      .on_time_cmp(on_time_cmp)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ------------------------------------------------
   // Watcher: pulse lengths, dead time and queued notes
   // ------------------------------------------------
   always @(negedge clock) begin
      cycles++;
      if (gh) hc++;
      if (gl) lc++;
      if (!gh && !gl) dc++;
      if (pgh && !gh) begin
         h  = hc;
         hc = 0;
         dc = 0;
      end
      if (!pgl && gl) check(dc, `RSSO_DEAD_CYC);
      if (pgl && !gl) begin
         check(lc, h);
         lc = 0;
         if (done_cyc == 0) h0 = h;
         done_cyc++;
         if (notes.size() > 0) begin
            nt = notes.pop_front();
            check(h - h0, nt.dh);
            check(dac, nt.dac);
         end
      end
      pgh = gh;
      pgl = gl;
      if (cycles == 80000) begin
         err_count++;
         results();
      end
   end

   // ------------------------------------------------
   // Stimulus, driven on the falling edge
   // ------------------------------------------------
   initial begin
      err_count = 0; num_checks = 0; cycles = 0; hc = 0; lc = 0; dc = 0;
      h = 0; h0 = 0; done_cyc = 0; pgh = 0; pgl = 0;
      srst = 1'b1; startup_done = 1'b0; startup_on_time = 12'h000;
      zvs_time_short = 1'b0; fb_below_skip_entry = 1'b0; cs_en = 1'b0; cmp_en = 1'b0;
      fb_below_light_load = 1'b0; fb_below_quiet_skip = 1'b0;
      void'($urandom(93025));
      repeat (2) @(negedge clock);
      srst = 1'b0;
      @(negedge clock);
      check({gh, gl, prot, ss_act}, 16'h0000);
      check(dac, 16'h0000);
      // Startup without a short ZVS time must not start switching
      n0 = 12'h040 + 12'($urandom % 64);
      startup_on_time = n0;
      startup_done = 1'b1;
      repeat (6) @(negedge clock);
      check(gh, 1'b0);
      zvs_time_short = 1'b1;
      @(negedge clock);
      startup_done = 1'b0;
      zvs_time_short = 1'b0;
      startup_on_time = 12'($urandom);
      @(negedge clock);
      check({ss_act, rep_en}, 16'h0002);
      for (i = 0; i < 3; i++) begin
         nt.dh  = 12'(i * 4);
         nt.dac = n0 + 12'((i + 1) * `RSSO_SS_STEP);
         notes.push_back(nt);
      end
      for (i = 0; i < 4000 && done_cyc < 3; i++) @(negedge clock);
      check(h0 >= n0 - 2 && h0 <= n0 + 2, 1'b1);
      // Current sense cuts the high side short; comparator drops every cycle
      cs_en = 1'b1;
      cmp_en = 1'b1;
      for (i = 0; i < 3000 && !rep_en; i++) @(negedge clock);
      check(rep_en, 1'b1);
      check(h < 40, 1'b1);
      check(prot, 1'b0);
      // Feedback below skip entry ends soft-start at once
      fb_below_skip_entry = 1'b1;
      for (i = 0; i < 300 && dac !== 12'hfff; i++) @(negedge clock);
      check(dac, `RSSO_MAX_ON);
      check(ss_act, 1'b0);
      fb_below_skip_entry = 1'b0;
      // Regulation lost: every high pulse runs to the maximum on-time
      cs_en = 1'b0;
      cmp_en = 1'b0;
      for (i = 0; i < 60000 && !prot; i++) @(negedge clock);
      check(prot, 1'b1);
      // The cycle in flight finishes its low half before the fault state
      for (i = 0; i < 100 && gl !== 1'b1; i++) @(negedge clock);
      for (i = 0; i < 5000 && gl === 1'b1; i++) @(negedge clock);
      repeat (20) @(negedge clock);
      check({gh, gl, prot}, 16'h0001);
      // Reset in mid-run clears the latch; restart and end soft-start early
      srst = 1'b1;
      repeat (4) @(negedge clock);
      srst = 1'b0;
      @(negedge clock);
      check({gh, gl, prot, ss_act}, 16'h0000);
      startup_on_time = n0;
      startup_done = 1'b1;
      zvs_time_short = 1'b1;
      cs_en = 1'b1;
      @(negedge clock);
      startup_done = 1'b0;
      zvs_time_short = 1'b0;
      fb_below_skip_entry = 1'b1;
      for (i = 0; i < 2000 && ss_act === 1'b1; i++) @(negedge clock);
      check(dac, `RSSO_MAX_ON);
      fb_below_skip_entry = 1'b0;
      // Light load: off-time after each low pulse
      fb_below_light_load = 1'b1;
      for (i = 0; i < 500 && gl !== 1'b1; i++) @(negedge clock);
      for (i = 0; i < 500 && gl === 1'b1; i++) @(negedge clock);
      for (off = 0; off < 3000 && gh !== 1'b1; off++) @(negedge clock);
      check(off >= `RSSO_SKIP_OFF_CYC && off <= `RSSO_SKIP_OFF_CYC + 2 * `RSSO_DEAD_CYC, 1'b1);
      check(qsa, 1'b0);
      fb_below_quiet_skip = 1'b1;
      repeat (8) @(negedge clock);
      check(qsa, 1'b1);
      results();
   end
endmodule
